/* core/bus_match_pkg.sv */
// shared constants for the read-port bus-matching path
package bus_match_pkg;
   localparam int LONG_W = 36;
   localparam int WORD_W = 18;
   localparam int BYTE_W = 9;
   localparam logic [1:0] PIECES_WORD = 2'h1; // last piece index, word
   localparam logic [1:0] PIECES_BYTE = 2'h3; // last piece index, byte
   localparam logic [1:0] PIECE_RST = 2'h0;
   localparam logic [LONG_W-1:0] DATA_RST = 36'h000000000;
   localparam int DEPTH = 256;
   localparam int ADDR_W = 8;
   localparam logic [ADDR_W:0] PTR_RST = 9'h000;
   localparam int FT_LATENCY = 3; // write-to-ready, read-clock cycles
   localparam logic [1:0] FT_CNT_RST = 2'h0;
   typedef enum logic [1:0] {WIDTH_LONG, WIDTH_WORD, WIDTH_BYTE} width_t;
endpackage

/* core/bus_matching_read_path.sv */
// fifo store, read-port bus matching and mailbox lane limits
`timescale 1ns/100ps
`default_nettype none

// Summary of operation
// - write-port mail read drives 36, low 18 or low 9 lines
// - mail register changes only on a write, never on a read
// - mail transfers bypass byte ordering entirely
// - match low gives long; high with size low word, high byte
// - width and timing take effect when reset completes
// - byte order sampled at master reset rise; high is msb first
// - in long width the byte order has no effect
// - memory holds whole 36-bit long words; split after fetch
// - word/byte mail uses only lanes 0-17 or 0-8
// - long width moves whole fetched word to output at once
// - word/byte: first piece shown, rest held in auxiliary regs
// - long width keeps every byte lane in place
// - word width: big order high half first, little low first
// - byte width: four reads, big from msb down, little from lsb up
// - unused read lanes are driven low in word or byte width
// - timing select high makes ready rise one cycle earlier, in fall-through mode only
// - fifo writes ignored until full/input-ready goes high
// - fall-through: word shown and ready within three read cycles
// - ready drops on last piece read, not on the long fetch
// - mail write drops its flag; writes ignored while flag low
// - write-port mail read returns mail and raises its flag
module bus_matching_read_path (
   input wire logic clk,
   input wire logic rst_b,
   input wire logic clk_en,
   input wire logic master_reset_n,
   input wire logic partial_reset_n,
   input wire logic match_select,
   input wire logic size_select,
   input wire logic order_timing_select,
   input wire logic fall_through_mode,
   input wire logic wr_en,
   input wire logic [35:0] wr_data,
   input wire logic rd_en,
   input wire logic mail_a_wr,
   input wire logic [35:0] mail_a_wdata,
   input wire logic mail_a_rd,
   input wire logic mail_b_wr,
   input wire logic [35:0] mail_b_wdata,
   input wire logic mail_b_rd,
   output logic [35:0] rd_data,
   output logic [35:0] mail_a_rdata,
   output logic [35:0] mail_b_rdata,
   output logic full_or_in_ready,
   output logic empty_or_out_ready,
   output logic mail_to_rport_flag,
   output logic mail_to_wport_flag
);
   localparam logic [1:0] FT_CNT_MAX = 2'(bus_match_pkg::FT_LATENCY - 1);

   // synchronisers for the reset pins and the strap-like selects
   logic [1:0] mrst_s_q, prst_s_q, bm_s_q, sz_s_q, ots_s_q, ft_s_q;
   logic mrst_d1_q, prst_d1_q;
   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         mrst_s_q <= 2'h0;
         prst_s_q <= 2'h0;
         bm_s_q <= 2'h0;
         sz_s_q <= 2'h0;
         ots_s_q <= 2'h0;
         ft_s_q <= 2'h0;
         mrst_d1_q <= 1'b0;
         prst_d1_q <= 1'b0;
      end else if (clk_en) begin
         mrst_s_q <= {mrst_s_q[0], master_reset_n};
         prst_s_q <= {prst_s_q[0], partial_reset_n};
         bm_s_q <= {bm_s_q[0], match_select};
         sz_s_q <= {sz_s_q[0], size_select};
         ots_s_q <= {ots_s_q[0], order_timing_select};
         ft_s_q <= {ft_s_q[0], fall_through_mode};
         mrst_d1_q <= mrst_s_q[1];
         prst_d1_q <= prst_s_q[1];
      end
   end

   logic in_reset, mrst_rise, reset_done;
   assign in_reset = !mrst_s_q[1] || !prst_s_q[1];
   assign mrst_rise = mrst_s_q[1] && !mrst_d1_q;
   assign reset_done = (mrst_s_q[1] && !mrst_d1_q && prst_s_q[1])
      || (prst_s_q[1] && !prst_d1_q && mrst_s_q[1]);

   // width latched at reset completion, order at master reset rise
   bus_match_pkg::width_t width_q;
   logic big_q, ft_q, ready_q, early_q;
   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         width_q <= bus_match_pkg::WIDTH_LONG;
         big_q <= 1'b0;
         ft_q <= 1'b0;
         early_q <= 1'b0;
         ready_q <= 1'b0;
      end else if (clk_en) begin
         if (mrst_rise) begin
            big_q <= ots_s_q[1];
         end
         if (reset_done) begin
            if (!bm_s_q[1]) begin
               width_q <= bus_match_pkg::WIDTH_LONG;
            end else if (!sz_s_q[1]) begin
               width_q <= bus_match_pkg::WIDTH_WORD;
            end else begin
               width_q <= bus_match_pkg::WIDTH_BYTE;
            end
            ft_q <= ft_s_q[1];
            early_q <= ots_s_q[1];
         end
         ready_q <= !in_reset && mrst_d1_q && prst_d1_q;
      end
   end

   // fifo memory of whole long words
   logic [35:0] mem [bus_match_pkg::DEPTH];
   logic [bus_match_pkg::ADDR_W:0] wptr_q, rptr_q;
   logic mem_full, mem_empty, fetch;
   assign mem_full = (wptr_q[bus_match_pkg::ADDR_W]
      != rptr_q[bus_match_pkg::ADDR_W])
      && (wptr_q[bus_match_pkg::ADDR_W-1:0]
      == rptr_q[bus_match_pkg::ADDR_W-1:0]);
   assign mem_empty = wptr_q == rptr_q;
   // no write is taken once a reset is seen, even before ready_q falls
   assign full_or_in_ready = ready_q && !mem_full && !in_reset;

   logic do_write;
   assign do_write = wr_en && full_or_in_ready;
   always_ff @(posedge clk) begin
      if (clk_en && do_write) begin
         mem[wptr_q[bus_match_pkg::ADDR_W-1:0]] <= wr_data;
      end
   end

   // pointers; reset or partial reset clears both
   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         wptr_q <= bus_match_pkg::PTR_RST;
         rptr_q <= bus_match_pkg::PTR_RST;
      end else if (clk_en) begin
         if (in_reset) begin
            wptr_q <= bus_match_pkg::PTR_RST;
            rptr_q <= bus_match_pkg::PTR_RST;
         end else begin
            if (do_write) begin
               wptr_q <= wptr_q + 1'b1;
            end
            if (fetch) begin
               rptr_q <= rptr_q + 1'b1;
            end
         end
      end
   end

   // piece sequencer and output register
   logic [1:0] piece_q, last_piece;
   logic [35:0] aux_q, out_q;
   logic out_valid_q, take, last_of_word;
   logic [1:0] ft_cnt_q;
   logic ft_wait;
   always_comb begin
      case (width_q)
         bus_match_pkg::WIDTH_WORD: last_piece = bus_match_pkg::PIECES_WORD;
         bus_match_pkg::WIDTH_BYTE: last_piece = bus_match_pkg::PIECES_BYTE;
         default: last_piece = bus_match_pkg::PIECE_RST;
      endcase
   end

   // picks piece n of a long word, placed in the low lanes
   function automatic logic [35:0] pick(input logic [35:0] w,
      input bus_match_pkg::width_t wd, input logic big, input logic [1:0] n);
      logic [1:0] k;
      pick = w;
      k = big ? 2'(2'h3 - n) : n;
      if (wd == bus_match_pkg::WIDTH_WORD) begin
         pick = {18'h00000, (big ? !n[0] : n[0]) ? w[35:18] : w[17:0]};
      end else if (wd == bus_match_pkg::WIDTH_BYTE) begin
         pick = {27'h0000000, w[9*k +: 9]};
      end
   endfunction

   assign last_of_word = piece_q == last_piece;
   assign take = rd_en && out_valid_q;
   // fetch when output empty or the last piece is being consumed
   assign fetch = !mem_empty && !in_reset && !ft_wait
      && (!out_valid_q || (take && last_of_word));
   assign ft_wait = ft_q && !out_valid_q && (ft_cnt_q != FT_CNT_MAX);
   assign rd_data = out_q;
   assign empty_or_out_ready = out_valid_q;

   // fall-through delay counter from first word in an empty fifo
   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         ft_cnt_q <= bus_match_pkg::FT_CNT_RST;
      end else if (clk_en) begin
         if (in_reset || out_valid_q || mem_empty) begin
            ft_cnt_q <= early_q ? 2'h1 : bus_match_pkg::FT_CNT_RST;
         end else if (ft_cnt_q != FT_CNT_MAX) begin
            ft_cnt_q <= ft_cnt_q + 2'h1;
         end
      end
   end

   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         piece_q <= bus_match_pkg::PIECE_RST;
         aux_q <= bus_match_pkg::DATA_RST;
         out_q <= bus_match_pkg::DATA_RST;
         out_valid_q <= 1'b0;
      end else if (clk_en) begin
         if (in_reset) begin
            piece_q <= bus_match_pkg::PIECE_RST;
            aux_q <= bus_match_pkg::DATA_RST;
            out_q <= bus_match_pkg::DATA_RST; // old width must not linger
            out_valid_q <= 1'b0;
         end else if (fetch) begin
            aux_q <= mem[rptr_q[bus_match_pkg::ADDR_W-1:0]];
            out_q <= pick(mem[rptr_q[bus_match_pkg::ADDR_W-1:0]],
               width_q, big_q, 2'h0);
            piece_q <= bus_match_pkg::PIECE_RST;
            out_valid_q <= 1'b1;
         end else if (take) begin
            if (last_of_word) begin
               out_valid_q <= 1'b0;
            end else begin
               out_q <= pick(aux_q, width_q, big_q, 2'(piece_q + 2'h1));
               piece_q <= piece_q + 2'h1;
            end
         end
      end
   end

   // lane mask for mailbox data by selected width
   function automatic logic [35:0] lanes(input logic [35:0] d,
      input bus_match_pkg::width_t wd);
      lanes = d;
      if (wd == bus_match_pkg::WIDTH_WORD) begin
         lanes = {18'h00000, d[17:0]};
      end else if (wd == bus_match_pkg::WIDTH_BYTE) begin
         lanes = {27'h0000000, d[8:0]};
      end
   endfunction

   // mail registers, no reordering on either path
   logic [35:0] mail1_q, mail2_q;
   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         mail1_q <= bus_match_pkg::DATA_RST;
         mail2_q <= bus_match_pkg::DATA_RST;
         mail_to_rport_flag <= 1'b1;
         mail_to_wport_flag <= 1'b1;
      end else if (clk_en) begin
         if (!mrst_s_q[1]) begin
            mail_to_rport_flag <= 1'b1;
            mail_to_wport_flag <= 1'b1;
         end else begin
            if (mail_a_wr && mail_to_rport_flag) begin
               mail1_q <= lanes(mail_a_wdata, width_q);
               mail_to_rport_flag <= 1'b0;
            end else if (mail_b_rd) begin
               mail_to_rport_flag <= 1'b1;
            end
            if (mail_b_wr && mail_to_wport_flag) begin
               mail2_q <= lanes(mail_b_wdata, width_q);
               mail_to_wport_flag <= 1'b0;
            end else if (mail_a_rd) begin
               mail_to_wport_flag <= 1'b1;
            end
         end
      end
   end
   assign mail_a_rdata = mail2_q;
   assign mail_b_rdata = mail1_q;

   // checks beside the logic

   // write gate; a reset clears the pointers, so it is left out here
   a_write_gate: assert property (@(posedge clk) disable iff (!rst_b)
      clk_en && wr_en && !full_or_in_ready && !in_reset
      |=> $stable(wptr_q))
      else $error("write taken while not ready");

   // mail registers and their flags
   a_mail_hold: assert property (@(posedge clk) disable iff (!rst_b)
      clk_en && !mail_a_wr && mrst_s_q[1] |=> $stable(mail1_q))
      else $error("mail register changed without write");
   a_mail_flag_low: assert property (@(posedge clk) disable iff (!rst_b)
      clk_en && mail_a_wr && mail_to_rport_flag && mrst_s_q[1]
      |=> !mail_to_rport_flag)
      else $error("mail flag not lowered by write");
   a_mail_flag_up: assert property (@(posedge clk) disable iff (!rst_b)
      clk_en && mail_a_rd && !(mail_b_wr && mail_to_wport_flag)
      |=> mail_to_wport_flag)
      else $error("mail flag not raised by read");
   // mail lane limits right after an accepted write
   a_mail_byte: assert property (@(posedge clk) disable iff (!rst_b)
      clk_en && mail_a_wr && mail_to_rport_flag && mrst_s_q[1]
      && width_q == bus_match_pkg::WIDTH_BYTE
      |=> mail1_q[35:9] == 27'h0000000)
      else $error("mail byte lanes leaked");
   a_mail_word: assert property (@(posedge clk) disable iff (!rst_b)
      clk_en && mail_b_wr && mail_to_wport_flag && mrst_s_q[1]
      && width_q == bus_match_pkg::WIDTH_WORD
      |=> mail_a_rdata[35:18] == 18'h00000)
      else $error("mail word lanes leaked");

   // unused read lanes stay quiet
   a_word_lanes: assert property (@(posedge clk) disable iff (!rst_b)
      width_q == bus_match_pkg::WIDTH_WORD |-> rd_data[35:18] == 18'h00000)
      else $error("upper word lanes driven");
   a_byte_lanes: assert property (@(posedge clk) disable iff (!rst_b)
      width_q == bus_match_pkg::WIDTH_BYTE |-> rd_data[35:9] == 27'h0000000)
      else $error("upper byte lanes driven");

   // piece order after the first piece, ready drop and whole long fetch
   a_byte_second: assert property (@(posedge clk) disable iff (!rst_b)
      clk_en && take && !last_of_word && big_q && !in_reset
      && width_q == bus_match_pkg::WIDTH_BYTE && piece_q == 2'h0
      |=> rd_data[8:0] == $past(aux_q[26:18]))
      else $error("byte order wrong");
   a_word_second: assert property (@(posedge clk) disable iff (!rst_b)
      clk_en && take && !last_of_word && !in_reset
      && width_q == bus_match_pkg::WIDTH_WORD
      |=> rd_data[17:0] == (big_q ? $past(aux_q[17:0])
      : $past(aux_q[35:18])))
      else $error("word order wrong");
   a_last_drop: assert property (@(posedge clk) disable iff (!rst_b)
      clk_en && take && last_of_word && mem_empty && !in_reset
      |=> !empty_or_out_ready)
      else $error("ready not dropped on last piece");
   a_long_whole: assert property (@(posedge clk) disable iff (!rst_b)
      clk_en && fetch && width_q == bus_match_pkg::WIDTH_LONG
      |=> rd_data == $past(mem[rptr_q[bus_match_pkg::ADDR_W-1:0]]))
      else $error("long word not moved whole");

   // reset, order latch and fall-through latency
   a_reset_seq: assert property (@(posedge clk) disable iff (!rst_b)
      clk_en && in_reset |=> piece_q == 2'h0 && !empty_or_out_ready)
      else $error("sequencer not restarted");
   a_order_latch: assert property (@(posedge clk) disable iff (!rst_b)
      clk_en && mrst_rise |=> big_q == $past(ots_s_q[1]))
      else $error("byte order not taken at reset rise");
   a_early_count: assert property (@(posedge clk) disable iff (!rst_b)
      clk_en && in_reset && early_q |=> ft_cnt_q == 2'h1)
      else $error("early ready count not preset");
   a_ft_ready: assert property (@(posedge clk) disable iff (!rst_b)
      clk_en && !out_valid_q && !mem_empty && !in_reset
      |-> ##[1:3] (out_valid_q || in_reset || !clk_en))
      else $error("first word not shown in time");

   // main scenarios
   c_byte_read: cover property (@(posedge clk) disable iff (!rst_b)
      take && width_q == bus_match_pkg::WIDTH_BYTE && last_of_word);
   c_word_read: cover property (@(posedge clk) disable iff (!rst_b)
      take && width_q == bus_match_pkg::WIDTH_WORD && last_of_word);
   c_long_read: cover property (@(posedge clk) disable iff (!rst_b)
      take && width_q == bus_match_pkg::WIDTH_LONG);
   c_ft_fill: cover property (@(posedge clk) disable iff (!rst_b)
      ft_q && fetch && !out_valid_q);
   c_mail_pass: cover property (@(posedge clk) disable iff (!rst_b)
      mail_a_wr && mail_to_rport_flag ##[1:20] mail_b_rd);
endmodule
`default_nettype wire

/* tb/piece_reader.sv */
// far-side reader model that pulls pieces off the read port
`timescale 1ns/100ps
`default_nettype none
module piece_reader (
   input wire logic clk,
   input wire logic rst_b,
   input wire logic stall,
   input wire logic ready,
   input wire logic [35:0] data,
   output logic rd_en,
   output logic got_valid,
   output logic [35:0] got_data
);
   // read strobe held up unless told to stall
   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         rd_en <= 1'b0;
      end else begin
         rd_en <= !stall;
      end
   end
   // a piece counts only where ready met the strobe
   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         got_valid <= 1'b0;
         got_data <= 36'h000000000;
      end else begin
         got_valid <= rd_en && ready;
         got_data <= data;
      end
   end
endmodule
`default_nettype wire

/* tb/bus_matching_read_path_bench.sv */
// self-checking bench for the bus-matching read path
`timescale 1ns/100ps
`default_nettype none
module bus_matching_read_path_bench;
   logic clk, rst_b, clk_en, master_reset_n, partial_reset_n;
   logic match_select, size_select, order_timing_select;
   logic fall_through_mode, wr_en, rd_en, mail_a_wr, mail_a_rd;
   logic mail_b_wr, mail_b_rd, full_or_in_ready, empty_or_out_ready;
   logic mail_to_rport_flag, mail_to_wport_flag, stall, hold, got_valid;
   logic [35:0] wr_data, mail_a_wdata, mail_b_wdata, rd_data;
   logic [35:0] mail_a_rdata, mail_b_rdata, got_data;
   logic [35:0] q[$];
   logic [35:0] w[3];
   logic [2:0] modes[6];
   logic big;
   int seed, miscompares, cmp_count, cyc, m, k, t;

   bus_matching_read_path i_bus_matching_read_path (
      .clk, .rst_b, .clk_en, .master_reset_n, .partial_reset_n,
      .match_select, .size_select, .order_timing_select,
      .fall_through_mode, .wr_en, .wr_data, .rd_en, .mail_a_wr,
      .mail_a_wdata, .mail_a_rd, .mail_b_wr, .mail_b_wdata, .mail_b_rd,
      .rd_data, .mail_a_rdata, .mail_b_rdata, .full_or_in_ready,
      .empty_or_out_ready, .mail_to_rport_flag, .mail_to_wport_flag
   );
   piece_reader i_piece_reader (
      .clk, .rst_b, .stall, .ready(empty_or_out_ready), .data(rd_data),
      .rd_en, .got_valid, .got_data
   );

   // free-running clock
   initial begin
      clk = 1'b0;
      forever #5 clk = ~clk;
   end
   // lane mask of the selected width
   function automatic logic [35:0] lanes(input int mode);
      if (mode == 0) return 36'hFFFFFFFFF;
      return mode == 1 ? 36'h00003FFFF : 36'h0000001FF;
   endfunction
   // n-th expected piece of a long word
   function automatic logic [35:0] piece(input logic [35:0] lw,
      input int mode, input logic msb_first, input int n);
      int wd, cnt, idx;
      if (mode == 0) return lw;
      wd = mode == 1 ? 18 : 9;
      cnt = 36 / wd;
      idx = msb_first ? cnt - 1 - n : n;
      return (lw >> (idx * wd)) & lanes(mode);
   endfunction
   task automatic chk_data(input logic [35:0] got, input logic [35:0] exp);
      cmp_count++;
      if (got !== exp) begin
         miscompares++;
         $display("[FAIL] %0t data %h expected %h", $time, got, exp);
      end
   endtask
   task automatic chk_flag(input logic got, input logic exp);
      cmp_count++;
      if (got !== exp) begin
         miscompares++;
         $display("[FAIL] %0t flag %b expected %b", $time, got, exp);
      end
   endtask
   task automatic end_of_test;
      $display("compares %0d mismatches %0d", cmp_count, miscompares);
      if (miscompares == 0 && cmp_count > 0) begin
         $display("Result: passed");
      end else begin
         $display("Result: failed");
      end
      $finish;
   endtask
   // cut a hang short
   always @(posedge clk) begin
      cyc++;
      if (cyc == 3000) begin
         miscompares++;
         end_of_test();
      end
   end
   // random reader stalls and piece capture
   always @(posedge clk) begin
      stall <= hold | (($random(seed) & 3) == 0);
      if (got_valid) q.push_back(got_data);
   end
   // pulse one reset pin, try writes meanwhile, wait for input ready
   task automatic dev_reset(input logic part);
      if (part) partial_reset_n <= 1'b0;
      else master_reset_n <= 1'b0;
      wr_en <= 1'b1;
      repeat (4) @(posedge clk);
      master_reset_n <= 1'b1;
      partial_reset_n <= 1'b1;
      wr_en <= 1'b0;
      for (int j = 0; j < 40; j++) begin
         @(posedge clk);
         #1;
         if (full_or_in_ready === 1'b1) break;
      end
      chk_flag(full_or_in_ready, 1'b1);
      @(posedge clk);
      q.delete();
   endtask
   task automatic write_words(input int n);
      for (int j = 0; j < n; j++) begin
         wr_en <= 1'b1;
         wr_data <= w[j];
         @(posedge clk);
      end
      wr_en <= 1'b0;
   endtask
   // collect n long words worth of pieces and compare in order
   task automatic expect_pieces(input int n);
      for (int j = 0; j < 400 && q.size() < n * k; j++) @(posedge clk);
      #1;
      chk_data(36'(q.size()), 36'(n * k));
      for (int j = 0; j < n * k && j < q.size(); j++)
         chk_data(q[j] & lanes(m), piece(w[j / k], m, big, j % k));
      chk_flag(empty_or_out_ready, 1'b0);
      @(posedge clk);
   endtask
   // mail both ways, a refused second write, then reads
   task automatic mail_chk(input logic [35:0] d);
      mail_a_wr <= 1'b1;
      mail_a_wdata <= d;
      @(posedge clk);
      mail_a_wr <= 1'b0;
      mail_b_wr <= 1'b1;
      mail_b_wdata <= ~d;
      @(posedge clk);
      mail_b_wr <= 1'b0;
      mail_a_wr <= 1'b1;
      mail_a_wdata <= ~d;
      @(posedge clk);
      mail_a_wr <= 1'b0;
      mail_a_rd <= 1'b1;
      mail_b_rd <= 1'b1;
      #1;
      chk_flag(mail_to_rport_flag, 1'b0);
      chk_flag(mail_to_wport_flag, 1'b0);
      chk_data(mail_b_rdata & lanes(m), d & lanes(m));
      @(posedge clk);
      mail_a_rd <= 1'b0;
      mail_b_rd <= 1'b0;
      #1;
      chk_flag(mail_to_wport_flag, 1'b1);
      chk_flag(mail_to_rport_flag, 1'b1);
      chk_data(mail_a_rdata & lanes(m), ~d & lanes(m));
      chk_data(mail_b_rdata & lanes(m), d & lanes(m));
      @(posedge clk);
   endtask
   // main sequence
   initial begin
      seed = 29;
      {miscompares, cmp_count, cyc} = '0;
      {rst_b, master_reset_n, wr_en, mail_a_wr, mail_a_rd} = '0;
      {mail_b_wr, mail_b_rd, hold, stall, fall_through_mode} = '0;
      {match_select, size_select, order_timing_select} = '0;
      {wr_data, mail_a_wdata, mail_b_wdata} = '0;
      clk_en = 1'b1;
      partial_reset_n = 1'b1;
      modes = '{3'h0, 3'h3, 3'h5, 3'h4, 3'h7, 3'h6};
      repeat (6) @(posedge clk);
      rst_b <= 1'b1;
      for (t = 0; t < 6; t++) begin
         {match_select, size_select, order_timing_select} <= modes[t];
         fall_through_mode <= t[0];
         m = !modes[t][2] ? 0 : (modes[t][1] ? 2 : 1);
         k = m == 0 ? 1 : (m == 1 ? 2 : 4);
         big = modes[t][0];
         dev_reset(1'b0);
         w[0] = 36'h123456789;
         w[1] = 36'({$random(seed), $random(seed)});
         w[2] = ~w[1];
         write_words(3);
         expect_pieces(3);
         mail_chk(w[1]);
         $display("test %0d done", t);
      end
      // partial reset with a long word fetched but not read
      hold <= 1'b1;
      write_words(1);
      repeat (8) @(posedge clk);
      dev_reset(1'b1);
      w[0] = 36'({$random(seed), $random(seed)});
      hold <= 1'b0;
      write_words(1);
      expect_pieces(1);
      $display("partial reset test done");
      end_of_test();
   end
endmodule
`default_nettype wire
